// *** logic/icms_top.sv ***
// Bus control register, mode selection and two-wire bus monitor
`timescale 1ns/100ps
module icms_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o
);
  import icms_pkg::*;

  // ----------------------------------------------------------------
  // Pin sampling and bus events
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  icms_sync #(.WIDTH(2)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic enable_reg, enable_next, irq_en_reg, irq_en_next;
  logic mst_reg, mst_next, trs_reg, trs_next;
  logic irq_flag_reg, irq_flag_next;
  logic pend_reg, pend_next, pend_val_reg, pend_val_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] data_reg, data_next;
  logic [7:0] saddr_reg, saddr_next;
  logic [7:0] saddr2_reg, saddr2_next;
  icms_lnk_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic first_reg, first_next, addressed_reg, addressed_next;
  logic sda_drv_reg, sda_drv_next, scl_drv_reg, scl_drv_next;
  logic irq_reg, irq_next;
  logic [7:0] rdata_reg, rdata_next;
  logic busy, in_frame, tx_part, rx_part;
  logic arb_lost, addr_hit, ctrl_wr;
  logic [2:0] tx_idx;
  assign busy = (state_reg == LNK_BUSY);
  assign in_frame = busy && (bit_cnt_reg != 4'h0);
  assign tx_part = trs_reg & (mst_reg | addressed_reg);
  assign rx_part = ~trs_reg & (mst_reg | addressed_reg);
  assign ctrl_wr = wr_i && (addr_i == OFF_CTRL);
  assign tx_idx = DATA_MSB - bit_cnt_reg[2:0];
  // lost when our released one reads back low
  assign arb_lost = enable_reg && busy && scl_rise && mst_reg &&
                    trs_reg && (bit_cnt_reg < DATA_BITS) &&
                    !sda_drv_reg && !sda_s;
  // address and direction seen at eighth clock
  assign addr_hit = enable_reg && busy && scl_rise && first_reg &&
                    !mst_reg && !trs_reg && (bit_cnt_reg == ADDR_LAST) &&
                    ((shift_reg[6:0] == saddr_reg[7:1]) ||
                     (shift_reg[6:0] == saddr2_reg[7:1]));

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    enable_next = enable_reg;
    irq_en_next = irq_en_reg;
    mst_next = mst_reg;
    trs_next = trs_reg;
    irq_flag_next = irq_flag_reg;
    pend_next = pend_reg;
    pend_val_next = pend_val_reg;
    mode_next = mode_reg;
    data_next = data_reg;
    saddr_next = saddr_reg;
    saddr2_next = saddr2_reg;
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    first_next = first_reg;
    addressed_next = addressed_reg;
    sda_drv_next = sda_drv_reg;
    rdata_next = 8'h00;
    if (ctrl_wr) begin
      enable_next = wdata_i[BIT_ENABLE];
      irq_en_next = wdata_i[BIT_IRQ_EN];
      mst_next = wdata_i[BIT_MASTER];
      // hold a transmit change until frame end
      if (in_frame) begin
        pend_next = 1'b1;
        pend_val_next = wdata_i[BIT_TRANSMIT];
      end else begin
        trs_next = wdata_i[BIT_TRANSMIT];
      end
      if (!wdata_i[BIT_IRQ_FLAG]) begin
        irq_flag_next = 1'b0;
      end
    end
    // mode and data registers while enabled, slave addresses while disabled
    if (wr_i && addr_i == OFF_MODE_SADDR) begin
      if (enable_reg) begin
        mode_next = wdata_i;
      end else begin
        saddr_next = wdata_i;
      end
    end
    if (wr_i && addr_i == OFF_DATA_SADDR2) begin
      if (enable_reg) begin
        data_next = wdata_i;
      end else begin
        saddr2_next = wdata_i;
      end
    end
    // halted and released from both pins, or stop seen
    if (!enable_reg || stop_det) begin
      state_next = LNK_IDLE;
      bit_cnt_next = 4'h0;
      first_next = 1'b0;
      addressed_next = 1'b0;
      sda_drv_next = 1'b0;
    end else if (start_det) begin
      state_next = LNK_BUSY;
      bit_cnt_next = 4'h0;
      first_next = 1'b1;
      addressed_next = 1'b0;
      sda_drv_next = 1'b0;
    end else if (busy && scl_rise) begin
      shift_next = {shift_reg[6:0], sda_s};
      if (bit_cnt_reg < FRAME_BITS) begin
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end
      // give up the bus and drop to slave receive
      if (arb_lost) begin
        mst_next = 1'b0;
        trs_next = 1'b0;
        pend_next = 1'b0;
        sda_drv_next = 1'b0;
      end
      // direction bit picks receive or transmit
      if (addr_hit) begin
        addressed_next = 1'b1;
        trs_next = sda_s;
      end
    end else if (busy && scl_fall) begin
      // data and acknowledge change only with clock low
      if (bit_cnt_reg == FRAME_BITS) begin
        bit_cnt_next = 4'h0;
        first_next = 1'b0;
        if (mst_reg | addressed_reg) begin
          irq_flag_next = 1'b1;
        end
        if (rx_part && !first_reg) begin
          data_next = shift_reg;
        end
        if (pend_next) begin
          trs_next = pend_val_next;
          pend_next = 1'b0;
        end
        sda_drv_next = trs_next & (mst_reg | addressed_reg) &
                       ~data_reg[DATA_MSB];
      end else if (bit_cnt_reg < DATA_BITS) begin
        sda_drv_next = tx_part & ~first_reg & ~data_reg[tx_idx];
      end else begin
        sda_drv_next = (first_reg & addressed_reg) |
                       (rx_part & ~first_reg);
      end
    end
    // stretch the clock while a request waits
    scl_drv_next = enable_reg && busy && irq_flag_next &&
                   (mst_reg || addressed_reg) &&
                   (scl_drv_reg || !scl_s);
    // request reaches the interrupt only when enabled
    // flag and enable, refreshed every cycle
    irq_next = irq_flag_reg & irq_en_reg;
    if (rd_i) begin
      case (addr_i)
        OFF_CTRL: rdata_next = {enable_reg, irq_en_reg, mst_reg, trs_reg,
                                1'b0, busy, irq_flag_reg, 1'b0};
        OFF_MODE_SADDR: rdata_next = enable_reg ? mode_reg : saddr_reg;
        OFF_DATA_SADDR2: rdata_next = enable_reg ? data_reg : saddr2_reg;
        OFF_STATUS: rdata_next = {5'h00, pend_reg, addressed_reg, first_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      enable_reg <= CTRL_RESET[BIT_ENABLE];
      irq_en_reg <= CTRL_RESET[BIT_IRQ_EN];
      // both mode bits start as slave receive
      mst_reg <= CTRL_RESET[BIT_MASTER];
      trs_reg <= CTRL_RESET[BIT_TRANSMIT];
      irq_flag_reg <= CTRL_RESET[BIT_IRQ_FLAG];
      pend_reg <= 1'b0;
      pend_val_reg <= 1'b0;
      mode_reg <= MODE_RESET;
      data_reg <= DATA_RESET;
      saddr_reg <= SADDR_RESET;
      saddr2_reg <= SADDR2_RESET;
      state_reg <= LNK_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      first_reg <= 1'b0;
      addressed_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      scl_drv_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      enable_reg <= enable_next;
      irq_en_reg <= irq_en_next;
      mst_reg <= mst_next;
      trs_reg <= trs_next;
      irq_flag_reg <= irq_flag_next;
      pend_reg <= pend_next;
      pend_val_reg <= pend_val_next;
      mode_reg <= mode_next;
      data_reg <= data_next;
      saddr_reg <= saddr_next;
      saddr2_reg <= saddr2_next;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      first_reg <= first_next;
      addressed_reg <= addressed_next;
      sda_drv_reg <= sda_drv_next;
      scl_drv_reg <= scl_drv_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end
  // Open-drain: pins only ever pulled low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_drv_reg;
  assign sda_oe_o = sda_drv_reg;
  assign irq_o = irq_reg;
  assign rdata_o = rdata_reg;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // no interrupt while enable held low
  a_irq_masked: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !irq_en_reg ##1 !irq_en_reg |-> !irq_o)
    else $error("interrupt raised while disabled");
  a_irq_follow: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (irq_flag_reg && irq_en_reg) ##1 (irq_flag_reg && irq_en_reg)
    |-> irq_o)
    else $error("interrupt missing with flag and enable");
  a_off_release: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !enable_reg |=> !sda_oe_o && !scl_oe_o)
    else $error("pin driven while disabled");
  a_arb_clear: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    arb_lost |=> !mst_reg && !trs_reg && !sda_oe_o)
    else $error("mode bits kept after lost arbitration");
  // direction bit lands in transmit select
  a_addr_dir: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    addr_hit |=> addressed_reg && !mst_reg && trs_reg == $past(sda_s))
    else $error("direction bit not applied");
  // transmit bit steady inside a frame
  a_trs_defer: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    ctrl_wr && in_frame && !arb_lost && !addr_hit &&
    !(scl_fall && bit_cnt_reg == FRAME_BITS)
    |=> trs_reg == $past(trs_reg) && pend_reg)
    else $error("transmit bit changed inside frame");
  a_read_mode: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_i && addr_i == OFF_MODE_SADDR && enable_reg
    |=> rdata_o == $past(mode_reg))
    else $error("mode register not visible");
  a_read_saddr: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    rd_i && addr_i == OFF_DATA_SADDR2 && !enable_reg
    |=> rdata_o == $past(saddr2_reg))
    else $error("slave address register not visible");
  a_mode_reset: assert property (
    @(posedge ref_clk_i)
    rst_i |=> !mst_reg && !trs_reg)
    else $error("mode bits not cleared by reset");
  // frame counter never passes nine clocks
  a_frame_len: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    bit_cnt_reg <= FRAME_BITS && (busy || bit_cnt_reg == 4'h0))
    else $error("frame bit count out of range");

endmodule

// *** logic/icms_pkg.sv ***
// Constants and types shared by the bus control and mode select block
package icms_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [1:0] OFF_CTRL = 2'h0;
  localparam logic [1:0] OFF_MODE_SADDR = 2'h1;
  localparam logic [1:0] OFF_DATA_SADDR2 = 2'h2;
  localparam logic [1:0] OFF_STATUS = 2'h3;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_MASTER = 5;
  localparam int BIT_TRANSMIT = 4;
  localparam int BIT_OCCUPIED = 2;
  localparam int BIT_IRQ_FLAG = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] SADDR_RESET = 8'h00;
  localparam logic [7:0] SADDR2_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Frame counts
  // ----------------------------------------------------------------
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'h9;
  localparam logic [3:0] ADDR_LAST = 4'h7;
  localparam logic [2:0] DATA_MSB = 3'h7;

  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LNK_IDLE = 2'b01,
    LNK_BUSY = 2'b10
  } icms_lnk_type;

endpackage

// *** logic/icms_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module icms_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------
  // Per-bit flip-flop pair
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;
      logic meta_next;
      logic out_reg;
      logic out_next;
      always_comb begin
        meta_next = async_i[g];
        out_next = meta_reg;
      end
      // Idle bus level is high
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          meta_reg <= 1'b1;
          out_reg <= 1'b1;
        end else begin
          meta_reg <= meta_next;
          out_reg <= out_next;
        end
      end
      assign sync_o[g] = out_reg;
    end
  endgenerate

endmodule

// *** tb/icms_bus_master_model.sv ***
// Far-side bus master model driving the shared clock and data wires
`timescale 1ns/100ps
module icms_bus_master_model (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o
);
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // Line primitives
  // ----------------------------------------------------------------
  // Release clock, then wait out a stretching slave, bounded
  task automatic clk_rel();
    int n;
    n = 0;
    scl_low_o = 1'b0;
    while (scl_i !== 1'b1 && n < 400) begin
      #10;
      n++;
    end
  endtask

  task automatic start_cond();
    sda_low_o = 1'b1;
    #62.5;
    scl_low_o = 1'b1;
    #31;
  endtask

  task automatic stop_cond();
    sda_low_o = 1'b1;
    #31.5;
    clk_rel();
    #62.5;
    sda_low_o = 1'b0;
    #62.5;
  endtask

  // Data set mid low phase, wire sampled mid high phase
  task automatic send_bit(input logic b, output logic s);
    sda_low_o = ~b;
    #31.5;
    clk_rel();
    #31;
    s = sda_i;
    #31.5;
    scl_low_o = 1'b1;
    #31;
  endtask

  // Eight bits first to last, then a released acknowledge slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i], s);
    end
    send_bit(1'b1, ack);
  endtask
endmodule

// *** tb/tb_icms_top.sv ***
// Self-checking bench for the bus control and mode select block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin \
  num_errors++; $display("wrong value %s exp %h got %h", nm, exp, got); end end
module tb_icms_top;
  import icms_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, m_scl, m_sda;
  wire scl_w = !(m_scl || (scl_oe_o && !scl_o));
  wire sda_w = !(m_sda || (sda_oe_o && !sda_o));
  int num_errors = 0;
  int check_count = 0;

  icms_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));

  icms_bus_master_model bm (.scl_i(scl_w), .sda_i(sda_w),
    .scl_low_o(m_scl), .sda_low_o(m_sda));

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic [1:0] exp_mode(input logic rw);
    return {1'b0, rw};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] r, sa, d, rnd, na;
    logic a;
    int i;
    rnd = 8'h4c;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rd(i[1:0], r);
      `CHK("reset value", 8'h00, r)
    end
    $display("test reset done");

    rnd = nxt(rnd);
    sa = {1'b1, rnd[5:0], 1'b0};
    rnd = nxt(rnd);
    d = rnd;
    wr(OFF_MODE_SADDR, sa);
    wr(OFF_DATA_SADDR2, d);
    wr(OFF_CTRL, 8'h80);
    wr(OFF_DATA_SADDR2, 8'hff);
    rd(OFF_DATA_SADDR2, r);
    `CHK("data reg", 8'hff, r)
    rd(OFF_MODE_SADDR, r);
    `CHK("mode reg", MODE_RESET, r)
    wr(OFF_MODE_SADDR, ~sa);
    rd(OFF_MODE_SADDR, r);
    `CHK("mode written", ~sa, r)
    wr(OFF_CTRL, 8'h00);
    rd(OFF_MODE_SADDR, r);
    `CHK("slave addr", sa, r)
    rd(OFF_DATA_SADDR2, r);
    `CHK("second addr", d, r)
    $display("test register map done");

    wr(OFF_CTRL, 8'h80);
    na = {sa[7:1] ^ 7'h01, 1'b0};
    bm.start_cond();
    for (i = 7; i > 4; i--) bm.send_bit(na[i], a);
    wr(OFF_CTRL, 8'h90);
    rd(OFF_STATUS, r);
    `CHK("change pending", 1'b1, r[2])
    rd(OFF_CTRL, r);
    `CHK("transmit early", 1'b0, r[BIT_TRANSMIT])
    for (i = 4; i >= 0; i--) bm.send_bit(na[i], a);
    bm.send_bit(1'b1, a);
    cyc(8);
    rd(OFF_CTRL, r);
    `CHK("transmit late", 1'b1, r[BIT_TRANSMIT])
    bm.stop_cond();
    $display("test deferred transmit done");

    for (i = 0; i < 2; i++) begin
      rd(OFF_CTRL, r);
      wr(OFF_CTRL, 8'hc0);
      bm.start_cond();
      bm.send_byte({sa[7:1], i[0]}, a);
      `CHK("address ack", 1'b0, a)
      wait_irq();
      `CHK("clock stretched", 1'b1, scl_oe_o)
      rd(OFF_CTRL, r);
      `CHK("mode after address", exp_mode(i[0]), r[5:4])
      `CHK("irq raised", 1'b1, irq_o)
      wr(OFF_CTRL, 8'h82);
      cyc(2);
      `CHK("irq masked", 1'b0, irq_o)
      rd(OFF_CTRL, r);
      `CHK("flag kept", 1'b1, r[BIT_IRQ_FLAG])
      wr(OFF_CTRL, 8'hc0);
      cyc(2);
      `CHK("irq cleared", 1'b0, irq_o)
      wr(OFF_CTRL, 8'h00);
      cyc(2);
      `CHK("data released", 1'b0, sda_oe_o)
      `CHK("clock released", 1'b0, scl_oe_o)
      bm.stop_cond();
    end
    $display("test slave address done");

    wr(OFF_CTRL, 8'h40);
    bm.start_cond();
    bm.send_byte({sa[7:1], 1'b0}, a);
    `CHK("no ack disabled", 1'b1, a)
    cyc(8);
    `CHK("no irq disabled", 1'b0, irq_o)
    bm.stop_cond();
    $display("test disabled done");

    wr(OFF_CTRL, 8'h80);
    wr(OFF_DATA_SADDR2, 8'hff);
    wr(OFF_CTRL, 8'hb0);
    bm.start_cond();
    bm.send_byte(8'h00, a);
    cyc(8);
    rd(OFF_CTRL, r);
    `CHK("mode after lost", 2'b00, r[5:4])
    bm.stop_cond();
    $display("test arbitration done");
    stop_test();
  end
endmodule
